// >>> pmbus_mfr_command_bank.sv
// Manufacturer command bank: settings, peak trackers, fault log and action commands.
// Assumes a bus engine on clk_sys that hands over one decoded command per strobe.
`include "mfr_bank_params.svh"

module pmbus_mfr_command_bank #(
	parameter int        LOG_BYTES     = 32,
	parameter logic [11:0] PART_CODE_HI = 12'h5A5
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Decoded command from the bus engine
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_write,
	input  wire logic        cmd_send,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        cmd_page,
	input  wire logic        log_next,
	input  wire logic        store_all_req,
	input  wire logic        restore_all_req,
	// Answer to the bus engine
	output logic             cmd_ready,
	output logic             rsp_valid,
	output logic             rsp_err,
	output logic [15:0]      rsp_data,
	// Measurements and device state
	input  wire logic        meas_valid,
	input  wire logic [15:0] meas_iout0,
	input  wire logic [15:0] meas_iout1,
	input  wire logic [15:0] meas_vout0,
	input  wire logic [15:0] meas_vout1,
	input  wire logic [15:0] meas_temp_ext0,
	input  wire logic [15:0] meas_temp_ext1,
	input  wire logic [15:0] meas_vin,
	input  wire logic [15:0] meas_temp_int,
	input  wire logic [15:0] pad_pins,
	input  wire logic [7:0]  status_in,
	input  wire logic [3:0]  part_variant,
	// Working fault log capture
	input  wire logic        log_wr_en,
	input  wire logic [7:0]  log_wr_idx,
	input  wire logic [7:0]  log_wr_data,
	// Settings to the power stage
	output mfr_bank_pkg::cfg_t settings,
	output logic             full_reset_pulse,
	output logic             compare_fail
);

	localparam int PK = 8;

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------

	// The log pointer is eight bits wide, so a longer log could not be walked.
	if (LOG_BYTES < 1 || LOG_BYTES > 255) begin
		$error("LOG_BYTES must lie between 1 and 255.");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------

	// The settings image, the nonvolatile image and both logs live in this one record.
	typedef struct packed {
		mfr_bank_pkg::state_t      st;
		logic                      ready;
		logic                      rsp_valid;
		logic                      rsp_err;
		logic [15:0]               rsp_data;
		logic                      full_reset;
		logic                      cmp_fail;
		mfr_bank_pkg::cfg_t        work;
		mfr_bank_pkg::cfg_t        nvm;
		logic [PK-1:0][15:0]       peak;
		logic [PK-1:0]             peak_ok;
		logic [LOG_BYTES-1:0][7:0] log_work;
		logic [LOG_BYTES-1:0][7:0] log_nvm;
		logic [7:0]                log_ptr;
		logic [15:0]               pad_s1;
		logic [15:0]               pad_s2;
	} bank_t;

	bank_t s;
	bank_t next_s;

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------

	// Linear-11 words are compared by value, so a change of exponent between samples
	// does not fool the tracker.
	function automatic logic signed [42:0] l11_val(input logic [15:0] w);
		logic signed [42:0] m;
		logic [4:0]         sh;
		m  = 43'(signed'(w[10:0]));
		sh = w[15:11] + 5'h10;
		return m <<< sh;
	endfunction

	function automatic mfr_bank_pkg::cfg_t cfg_default();
		mfr_bank_pkg::cfg_t c;
		c.fault_resp   = {2{`RST_FAULT_PIN_RESP}};
		c.retry_wait   = {2{`RST_RETRY_WAIT}};
		c.restart_hold = {2{`RST_RESTART_HOLD}};
		c.bus_addr     = `RST_BUS_ADDRESS;
		c.rail_addr    = {2{`RST_RAIL_ADDRESS}};
		c.pwm_cfg      = `RST_PWM_CONFIG;
		c.tempco       = {2{`RST_SENSE_TEMPCO}};
		c.slope        = {2{`RST_EXT_TEMP_SLOPE}};
		c.offset       = {2{`RST_EXT_TEMP_OFFSET}};
		return c;
	endfunction

	// ----------------------------------------
	// Measurement slots
	// ----------------------------------------

	// Peak slots: 0-1 current, 2-3 output voltage, 4-5 external temp, 6 input V, 7 int temp.
	logic [PK-1:0][15:0] sample;
	assign sample = {meas_temp_int, meas_vin, meas_temp_ext1, meas_temp_ext0,
		meas_vout1, meas_vout0, meas_iout1, meas_iout0};

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------

	always_comb begin
		logic       hit;
		logic       wr;
		logic       rd;
		logic       act;
		logic       pg;
		logic       larger;

		// ----------------------------------------
		// Defaults and strobes
		// ----------------------------------------
		next_s            = s;
		hit               = 1'b1;
		wr                = cmd_valid && s.ready && cmd_write && !cmd_send;
		rd                = cmd_valid && s.ready && !cmd_write && !cmd_send;
		act               = cmd_valid && s.ready && cmd_send;
		pg                = cmd_page;
		larger            = 1'b0;
		next_s.rsp_valid  = 1'b0;
		next_s.rsp_err    = 1'b0;
		next_s.full_reset = 1'b0;
		next_s.pad_s1     = pad_pins;
		next_s.pad_s2     = s.pad_s1;

		// ----------------------------------------
		// Peak trackers
		// ----------------------------------------
		// Output voltage is unsigned, so its slots compare raw bits instead of values.
		// track peak values
		for (int i = 0; i < PK; i++) begin
			if (i == 2 || i == 3) begin
				larger = sample[i] > s.peak[i];
			end else begin
				larger = l11_val(sample[i]) > l11_val(s.peak[i]);
			end
			if (meas_valid && (!s.peak_ok[i] || larger)) begin
				next_s.peak[i]    = sample[i];
				next_s.peak_ok[i] = 1'b1;
			end
		end

		// ----------------------------------------
		// Fault log capture
		// ----------------------------------------
		// Indices beyond the log are dropped rather than wrapped onto early entries.
		if (log_wr_en && log_wr_idx < 8'(LOG_BYTES)) begin
			next_s.log_work[log_wr_idx] = log_wr_data;
		end

		// ----------------------------------------
		// Settings image
		// ----------------------------------------
		// store all settings
		if (store_all_req && s.ready) begin
			next_s.nvm = s.work;
		end

		// ----------------------------------------
		// Command service
		// ----------------------------------------
		// A log byte request wins over a command in the same cycle; the bus engine
		// raises only one of them while a block read is under way.
		case (s.st)
			mfr_bank_pkg::ST_LOAD: begin
				next_s.work  = s.nvm;
				next_s.ready = 1'b1;
				next_s.st    = mfr_bank_pkg::ST_RUN;
			end
			mfr_bank_pkg::ST_RUN: begin
				if (restore_all_req && s.ready) begin
					next_s.ready = 1'b0;
					next_s.st    = mfr_bank_pkg::ST_LOAD;
				end
				if (log_next && s.ready) begin
					// stream stored log
					// The last byte is flagged, then repeated, so an over-long read stays harmless.
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data  = 16'(s.log_nvm[s.log_ptr]);
					next_s.rsp_err   = s.log_ptr >= 8'(LOG_BYTES - 1);
					if (s.log_ptr < 8'(LOG_BYTES - 1)) begin
						next_s.log_ptr = s.log_ptr + 8'h01;
					end
				end else if (act) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data  = 16'h0000;
					if (cmd_code == `CMD_CLEAR_PEAKS) begin
						// restart peak tracking
						// Values are zeroed too, so a read before the next sample returns 0.
						next_s.peak    = '0;
						next_s.peak_ok = '0;
						for (int i = 0; i < PK; i++) begin
							if (meas_valid) begin
								next_s.peak[i]    = sample[i];
								next_s.peak_ok[i] = 1'b1;
							end
						end
					end else if (cmd_code == `CMD_LOG_STORE) begin
						next_s.log_nvm = s.log_work;
					end else if (cmd_code == `CMD_LOG_ERASE) begin
						next_s.log_nvm = {LOG_BYTES{`LOG_ERASED_BYTE}};
					end else if (cmd_code == `CMD_MEM_COMPARE) begin
						// compare working and stored
						// Only the settings image takes part; the fault log is not compared.
						next_s.cmp_fail = s.work != s.nvm;
					end else if (cmd_code == `CMD_FULL_RESET) begin
						next_s.full_reset = 1'b1;
						next_s.peak       = '0;
						next_s.peak_ok    = '0;
						next_s.log_work   = {LOG_BYTES{`LOG_ERASED_BYTE}};
						next_s.log_ptr    = 8'h00;
						next_s.cmp_fail   = 1'b0;
						next_s.ready      = 1'b0;
						next_s.st         = mfr_bank_pkg::ST_LOAD;
					end else begin
						next_s.rsp_err = 1'b1;
					end
				end else if (wr) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data  = 16'h0000;
					if (cmd_code == `CMD_FAULT_PIN_RESP) begin
						next_s.work.fault_resp[pg] = cmd_wdata[7:0];
					end else if (cmd_code == `CMD_RETRY_WAIT) begin
						next_s.work.retry_wait[pg] = cmd_wdata;
					end else if (cmd_code == `CMD_RESTART_HOLD) begin
						next_s.work.restart_hold[pg] = cmd_wdata;
					end else if (cmd_code == `CMD_BUS_ADDRESS) begin
						next_s.work.bus_addr = {1'b0, cmd_wdata[`ADDR_FIELD_MSB:0]};
					end else if (cmd_code == `CMD_RAIL_ADDRESS) begin
						// rail address keeps its top bit as written
						next_s.work.rail_addr[pg] = cmd_wdata[7:0];
					end else if (cmd_code == `CMD_PWM_CONFIG) begin
						next_s.work.pwm_cfg = cmd_wdata[7:0];
					end else if (cmd_code == `CMD_SENSE_TEMPCO) begin
						next_s.work.tempco[pg] = cmd_wdata;
					end else if (cmd_code == `CMD_EXT_TEMP_SLOPE) begin
						next_s.work.slope[pg] = cmd_wdata;
					end else if (cmd_code == `CMD_EXT_TEMP_OFFSET) begin
						next_s.work.offset[pg] = cmd_wdata;
					end else begin
						next_s.rsp_err = 1'b1;
					end
				end else if (rd) begin
					next_s.rsp_valid = 1'b1;
					next_s.rsp_data  = 16'h0000;
					if (cmd_code == `CMD_FAULT_PIN_RESP) begin
						next_s.rsp_data = 16'(s.work.fault_resp[pg]);
					end else if (cmd_code == `CMD_OVERTEMP_RESP) begin
						next_s.rsp_data = 16'(`VAL_OVERTEMP_RESP);
					end else if (cmd_code == `CMD_IOUT_PEAK) begin
						next_s.rsp_data = s.peak[pg ? 1 : 0];
					end else if (cmd_code == `CMD_RETRY_WAIT) begin
						next_s.rsp_data = s.work.retry_wait[pg];
					end else if (cmd_code == `CMD_RESTART_HOLD) begin
						next_s.rsp_data = s.work.restart_hold[pg];
					end else if (cmd_code == `CMD_VOUT_PEAK) begin
						next_s.rsp_data = s.peak[pg ? 3 : 2];
					end else if (cmd_code == `CMD_VIN_PEAK) begin
						next_s.rsp_data = s.peak[6];
					end else if (cmd_code == `CMD_EXT_TEMP_PEAK) begin
						next_s.rsp_data = s.peak[pg ? 5 : 4];
					end else if (cmd_code == `CMD_PAD_STATE) begin
						next_s.rsp_data = s.pad_s2;
					end else if (cmd_code == `CMD_BUS_ADDRESS) begin
						next_s.rsp_data = 16'(s.work.bus_addr);
					end else if (cmd_code == `CMD_PART_CODE) begin
						next_s.rsp_data = {PART_CODE_HI, part_variant};
					end else if (cmd_code == `CMD_LOG_READ) begin
						next_s.rsp_data = 16'(LOG_BYTES);
						next_s.log_ptr  = 8'h00;
					end else if (cmd_code == `CMD_FAMILY_STATUS) begin
						next_s.rsp_data = 16'(status_in);
					end else if (cmd_code == `CMD_INT_TEMP_PEAK) begin
						next_s.rsp_data = s.peak[7];
					end else if (cmd_code == `CMD_PWM_CONFIG) begin
						next_s.rsp_data = 16'(s.work.pwm_cfg);
					end else if (cmd_code == `CMD_SENSE_TEMPCO) begin
						next_s.rsp_data = s.work.tempco[pg];
					end else if (cmd_code == `CMD_EXT_TEMP_SLOPE) begin
						next_s.rsp_data = s.work.slope[pg];
					end else if (cmd_code == `CMD_EXT_TEMP_OFFSET) begin
						next_s.rsp_data = s.work.offset[pg];
					end else if (cmd_code == `CMD_RAIL_ADDRESS) begin
						next_s.rsp_data = 16'(s.work.rail_addr[pg]);
					end else begin
						// Unknown codes answer with an error flag and zero data.
						hit = 1'b0;
					end
					next_s.rsp_err = !hit;
				end
			end
			default: begin
				next_s.st = mfr_bank_pkg::ST_LOAD;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------

	// The nonvolatile image takes its defaults at reset; a real array would keep its
	// contents, which this flop model cannot do under an asynchronous reset.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s          <= '0;
			s.st       <= mfr_bank_pkg::ST_LOAD;
			s.work     <= cfg_default();
			s.nvm      <= cfg_default();
			s.log_work <= {LOG_BYTES{`LOG_ERASED_BYTE}};
			s.log_nvm  <= {LOG_BYTES{`LOG_ERASED_BYTE}};
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	// Every output is a field of the state register, so none passes through logic.
	assign cmd_ready        = s.ready;
	assign rsp_valid        = s.rsp_valid;
	assign rsp_err          = s.rsp_err;
	assign rsp_data         = s.rsp_data;
	assign settings         = s.work;
	assign full_reset_pulse = s.full_reset;
	assign compare_fail     = s.cmp_fail;

endmodule

// >>> mfr_bank_params.svh
// Constants of the manufacturer command bank: command codes, reset values, sizes.
// Assumes a bus engine outside that frames transactions into decoded command strobes.
//
// Behaviour
// - Clear-peaks command restarts every peak tracker on all channels.
// - Peak current, voltages and temperatures are tracked and read back as words.
// - Log-store command copies the working fault log into nonvolatile memory.
// - Log-erase command wipes the nonvolatile fault log.
// - Block read of the log command returns the stored fault log bytes.
// - Compare command checks every working setting against its nonvolatile copy.
// - Full-reset command resets the whole block as a power cycle would.
// - Bus address is a right-justified 7-bit value, default 0x4F, nonvolatile.
// - Per-channel rail address byte, all eight bits kept as written, default 0x80.
// - Per-channel restart hold word, default 0xFBE8, sets run-pin low time.
// - Per-channel retry wait word, default 0xFABC, sets wait before retry.
// - Per-channel fault-pin response byte, default 0xC0.
// - Overtemperature response byte reads 0xC0 and refuses writes.
// - Nonvolatile settings are stored by store-all and reloaded on power-up, restore, reset.
// - One shared PWM configuration byte, default 0x14.
// - Per-channel external temperature slope 0x4000 and offset 0x8000, nonvolatile.
// - Per-channel sense element tempco word, default 0x0F3C.
// - Read-only part code word whose lowest nibble varies.
// - Read-only word shows the synchronised state of selected pads.
// - Read-only byte gives the summary family status.
`ifndef MFR_BANK_PARAMS_SVH
`define MFR_BANK_PARAMS_SVH

`define CMD_FAULT_PIN_RESP   8'hD5
`define CMD_OVERTEMP_RESP    8'hD6
`define CMD_IOUT_PEAK        8'hD7
`define CMD_RETRY_WAIT       8'hDB
`define CMD_RESTART_HOLD     8'hDC
`define CMD_VOUT_PEAK        8'hDD
`define CMD_VIN_PEAK         8'hDE
`define CMD_EXT_TEMP_PEAK    8'hDF
`define CMD_CLEAR_PEAKS      8'hE3
`define CMD_PAD_STATE        8'hE5
`define CMD_BUS_ADDRESS      8'hE6
`define CMD_PART_CODE        8'hE7
`define CMD_LOG_STORE        8'hEA
`define CMD_LOG_ERASE        8'hEC
`define CMD_LOG_READ         8'hEE
`define CMD_FAMILY_STATUS    8'hEF
`define CMD_MEM_COMPARE      8'hF0
`define CMD_INT_TEMP_PEAK    8'hF4
`define CMD_PWM_CONFIG       8'hF5
`define CMD_SENSE_TEMPCO     8'hF6
`define CMD_EXT_TEMP_SLOPE   8'hF8
`define CMD_EXT_TEMP_OFFSET  8'hF9
`define CMD_RAIL_ADDRESS     8'hFA
`define CMD_FULL_RESET       8'hFD

`define RST_FAULT_PIN_RESP   8'hC0
`define VAL_OVERTEMP_RESP    8'hC0
`define RST_RETRY_WAIT       16'hFABC
`define RST_RESTART_HOLD     16'hFBE8
`define RST_BUS_ADDRESS      8'h4F
`define RST_RAIL_ADDRESS     8'h80
`define RST_PWM_CONFIG       8'h14
`define RST_SENSE_TEMPCO     16'h0F3C
`define RST_EXT_TEMP_SLOPE   16'h4000
`define RST_EXT_TEMP_OFFSET  16'h8000
`define LOG_ERASED_BYTE      8'hFF
`define ADDR_FIELD_MSB       6

`endif

// >>> mfr_bank_pkg.sv
// Types shared by the manufacturer command bank.
// Assumes two output channels.
package mfr_bank_pkg;

	typedef enum logic [0:0] {
		ST_LOAD = 1'b0,
		ST_RUN  = 1'b1
	} state_t;

	typedef struct packed {
		logic [1:0][7:0]  fault_resp;
		logic [1:0][15:0] retry_wait;
		logic [1:0][15:0] restart_hold;
		logic [7:0]       bus_addr;
		logic [1:0][7:0]  rail_addr;
		logic [7:0]       pwm_cfg;
		logic [1:0][15:0] tempco;
		logic [1:0][15:0] slope;
		logic [1:0][15:0] offset;
	} cfg_t;

endpackage

// >>> mfr_bank_asserts.sv
// Port assertions for the manufacturer command bank.
// Assumes one clock domain and one decoded command per strobe.
`include "mfr_bank_params.svh"
module mfr_bank_asserts (
	input wire logic               clk_sys,
	input wire logic               sys_rst,
	input wire logic               cmd_valid,
	input wire logic [7:0]         cmd_code,
	input wire logic               cmd_write,
	input wire logic               cmd_send,
	input wire logic [15:0]        cmd_wdata,
	input wire logic               cmd_page,
	input wire logic               log_next,
	input wire logic               cmd_ready,
	input wire logic               rsp_valid,
	input wire logic               rsp_err,
	input wire logic [15:0]        rsp_data,
	input wire mfr_bank_pkg::cfg_t settings,
	input wire logic               full_reset_pulse
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire take = cmd_valid && cmd_ready && !log_next;
	wire rd = take && !cmd_write && !cmd_send;
	wire wr = take && cmd_write && !cmd_send;
	property p_answer; (cmd_valid || log_next) && cmd_ready |=> rsp_valid; endproperty
	a_answer: assert property (p_answer) else $error("taken request not answered");
	property p_refuse; !cmd_ready |=> !rsp_valid; endproperty
	a_refuse: assert property (p_refuse) else $error("answer while not ready");
	property p_reset;
		take && cmd_send && cmd_code == `CMD_FULL_RESET |=> full_reset_pulse && !cmd_ready ##1 cmd_ready;
	endproperty
	a_reset: assert property (p_reset) else $error("full reset sequence wrong");
	property p_pulse; full_reset_pulse |=> !full_reset_pulse; endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_addr_rd;
		rd && cmd_code == `CMD_BUS_ADDRESS |=> rsp_data == {8'h00, $past(settings.bus_addr)};
	endproperty
	a_addr_rd: assert property (p_addr_rd) else $error("address read wrong");
	property p_addr7; !settings.bus_addr[`ADDR_FIELD_MSB + 1]; endproperty
	a_addr7: assert property (p_addr7) else $error("address wider than 7 bits");
	property p_retry_wr;
		wr && cmd_code == `CMD_RETRY_WAIT && cmd_page |=>
			settings.retry_wait[1] == $past(cmd_wdata) && rsp_data == 16'h0000;
	endproperty
	a_retry_wr: assert property (p_retry_wr) else $error("retry word not written");
	property p_ot_wr; wr && cmd_code == `CMD_OVERTEMP_RESP |=> rsp_err && $stable(settings); endproperty
	a_ot_wr: assert property (p_ot_wr) else $error("read-only byte accepted write");
	property p_ot_rd; rd && cmd_code == `CMD_OVERTEMP_RESP |=> rsp_data == 16'h00C0; endproperty
	a_ot_rd: assert property (p_ot_rd) else $error("overtemp byte wrong");
endmodule

bind pmbus_mfr_command_bank mfr_bank_asserts chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.cmd_write(cmd_write), .cmd_send(cmd_send), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page),
	.log_next(log_next), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
	.rsp_data(rsp_data), .settings(settings), .full_reset_pulse(full_reset_pulse)
);

// >>> host_model.sv
// Bus host model driving the decoded command strobes.
// Assumes the bank's answer is valid just after the same edge that takes a request.
module host_model (
	input wire logic        clk_sys,
	input wire logic        cmd_ready,
	input wire logic        rsp_valid,
	input wire logic        rsp_err,
	input wire logic [15:0] rsp_data,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code,
	output logic            cmd_write,
	output logic            cmd_send,
	output logic [15:0]     cmd_wdata,
	output logic            cmd_page,
	output logic            log_next
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Transfers
	// ----------------------------------------
	initial begin
		{cmd_valid, cmd_write, cmd_send, cmd_page, log_next} = 5'h00;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	task automatic xfer(input logic [7:0] c, input logic w, s, p, n, input logic [15:0] d,
			output logic [15:0] q, output logic e);
		int k;
		@(posedge clk_sys);
		#1;
		for (k = 0; k < 20 && cmd_ready !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		cmd_valid = !n;
		log_next = n;
		cmd_code = c;
		cmd_write = w;
		cmd_send = s;
		cmd_page = p;
		cmd_wdata = (s || !w) ? ~cmd_wdata : d;
		@(posedge clk_sys);
		#1;
		q = rsp_valid === 1'b1 ? rsp_data : 16'hXXXX;
		e = rsp_err;
		cmd_valid = 1'b0;
		log_next = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~cmd_wdata;
	endtask
endmodule

// >>> tb_top.sv
// Testbench of the command bank: register, peak, memory and log sequences.
// Assumes host_model frames every command and returns the answer.
`include "mfr_bank_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LB = 4;
	// Upper part code bits: arbitrary value.
	localparam logic [11:0] PC = 12'h3C3;
	localparam logic [7:0] PK [5] = '{8'hD7, 8'hDD, 8'hDF, 8'hDE, 8'hF4};
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid, cmd_write, cmd_send, cmd_page, log_next, cmd_ready, rsp_valid, rsp_err;
	logic [7:0] cmd_code, status_in = 8'h00, log_wr_idx = 8'h00, log_wr_data = 8'h00;
	logic [15:0] cmd_wdata, rsp_data, q, m0 = 16'h0000, m1 = 16'h0000, pad_pins = 16'h0000;
	logic store_all_req = 1'b0, restore_all_req = 1'b0, meas_valid = 1'b0, log_wr_en = 1'b0;
	logic full_reset_pulse, compare_fail, e;
	logic [3:0] part_variant = 4'h9;
	mfr_bank_pkg::cfg_t settings;
	int n_fail = 0;
	int checks_done = 0;
	pmbus_mfr_command_bank #(.LOG_BYTES(LB), .PART_CODE_HI(PC)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_write(cmd_write), .cmd_send(cmd_send), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page),
		.log_next(log_next), .store_all_req(store_all_req), .restore_all_req(restore_all_req),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
		.meas_valid(meas_valid), .meas_iout0(m0), .meas_iout1(m1), .meas_vout0(m0),
		.meas_vout1(m1), .meas_temp_ext0(m0), .meas_temp_ext1(m1), .meas_vin(m0),
		.meas_temp_int(m0), .pad_pins(pad_pins), .status_in(status_in),
		.part_variant(part_variant), .log_wr_en(log_wr_en), .log_wr_idx(log_wr_idx),
		.log_wr_data(log_wr_data), .settings(settings), .full_reset_pulse(full_reset_pulse),
		.compare_fail(compare_fail)
	);
	host_model host (
		.clk_sys(clk_sys), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
		.rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_write(cmd_write),
		.cmd_send(cmd_send), .cmd_wdata(cmd_wdata), .cmd_page(cmd_page), .log_next(log_next)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		checks_done++;
		if (g !== x) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task rdx(input logic [7:0] c, input logic p, input logic [15:0] x);
		host.xfer(c, 1'b0, 1'b0, p, 1'b0, 16'h0000, q, e);
		chk($sformatf("cmd %h page %0d", c, p), x, q);
	endtask
	task wr(input logic [7:0] c, input logic p, input logic [15:0] d);
		host.xfer(c, 1'b1, 1'b0, p, 1'b0, d, q, e);
		chk("write status", 16'h0000, {15'h0000, e});
	endtask
	task act(input logic [7:0] c);
		host.xfer(c, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, q, e);
	endtask
	task nxt(input logic [15:0] x, input logic xe);
		host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, q, e);
		chk("log byte", x, q);
		chk("log end", {15'h0000, xe}, {15'h0000, e});
	endtask
	task strobe(input logic r, input logic [15:0] v, input logic s);
		@(posedge clk_sys);
		#1;
		store_all_req = s && !r;
		restore_all_req = s && r;
		meas_valid = !s;
		m0 = v;
		m1 = v + 16'h0001;
		@(posedge clk_sys);
		#1;
		{store_all_req, restore_all_req, meas_valid} = 3'h0;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		for (int p = 0; p < 2; p++) begin
			rdx(`CMD_FAULT_PIN_RESP, p[0], {8'h00, `RST_FAULT_PIN_RESP});
			rdx(`CMD_RETRY_WAIT, p[0], `RST_RETRY_WAIT);
			rdx(`CMD_RESTART_HOLD, p[0], `RST_RESTART_HOLD);
			rdx(`CMD_RAIL_ADDRESS, p[0], {8'h00, `RST_RAIL_ADDRESS});
			rdx(`CMD_SENSE_TEMPCO, p[0], `RST_SENSE_TEMPCO);
			rdx(`CMD_EXT_TEMP_SLOPE, p[0], `RST_EXT_TEMP_SLOPE);
			rdx(`CMD_EXT_TEMP_OFFSET, p[0], `RST_EXT_TEMP_OFFSET);
		end
		rdx(`CMD_BUS_ADDRESS, 1'b0, {8'h00, `RST_BUS_ADDRESS});
		rdx(`CMD_PWM_CONFIG, 1'b0, {8'h00, `RST_PWM_CONFIG});
		chk("retry out", `RST_RETRY_WAIT, settings.retry_wait[1]);
		host.xfer(`CMD_OVERTEMP_RESP, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0011, q, e);
		chk("ro write", 16'h0001, {15'h0000, e});
		rdx(`CMD_OVERTEMP_RESP, 1'b0, 16'h00C0);
		wr(`CMD_BUS_ADDRESS, 1'b0, 16'h00FF);
		rdx(`CMD_BUS_ADDRESS, 1'b0, 16'h007F);
		wr(`CMD_RAIL_ADDRESS, 1'b1, 16'h0081);
		rdx(`CMD_RAIL_ADDRESS, 1'b1, 16'h0081);
		rdx(`CMD_RAIL_ADDRESS, 1'b0, 16'h0080);
		wr(`CMD_FAULT_PIN_RESP, 1'b1, 16'h0042);
		rdx(`CMD_FAULT_PIN_RESP, 1'b1, 16'h0042);
		rdx(`CMD_FAULT_PIN_RESP, 1'b0, {8'h00, `RST_FAULT_PIN_RESP});
		wr(`CMD_PWM_CONFIG, 1'b1, 16'h0033);
		rdx(`CMD_PWM_CONFIG, 1'b0, 16'h0033);
		wr(`CMD_SENSE_TEMPCO, 1'b1, 16'h0ABC);
		rdx(`CMD_SENSE_TEMPCO, 1'b1, 16'h0ABC);
		wr(`CMD_EXT_TEMP_SLOPE, 1'b1, 16'h2000);
		rdx(`CMD_EXT_TEMP_SLOPE, 1'b1, 16'h2000);
		wr(`CMD_EXT_TEMP_OFFSET, 1'b0, 16'h8123);
		rdx(`CMD_EXT_TEMP_OFFSET, 1'b0, 16'h8123);
		wr(`CMD_RETRY_WAIT, 1'b1, 16'h1234);
		rdx(`CMD_RETRY_WAIT, 1'b0, `RST_RETRY_WAIT);
		strobe(1'b0, m0, 1'b1);
		wr(`CMD_RETRY_WAIT, 1'b1, 16'h5555);
		strobe(1'b1, m0, 1'b1);
		rdx(`CMD_RETRY_WAIT, 1'b1, 16'h1234);
		act(`CMD_MEM_COMPARE);
		chk("compare equal", 16'h0000, {15'h0000, compare_fail});
		wr(`CMD_RESTART_HOLD, 1'b0, 16'h0001);
		act(`CMD_MEM_COMPARE);
		chk("compare differ", 16'h0001, {15'h0000, compare_fail});
		act(`CMD_FULL_RESET);
		chk("reset pulse", 16'h0001, {15'h0000, full_reset_pulse});
		rdx(`CMD_RESTART_HOLD, 1'b0, `RST_RESTART_HOLD);
		rdx(`CMD_RETRY_WAIT, 1'b1, 16'h1234);
		rdx(`CMD_EXT_TEMP_SLOPE, 1'b1, 16'h2000);
		chk("compare cleared", 16'h0000, {15'h0000, compare_fail});
		strobe(1'b0, 16'h0064, 1'b0);
		strobe(1'b0, 16'h0032, 1'b0);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 5; i++) begin
				rdx(PK[i], p[0], (i < 3 && p == 1) ? 16'h0065 : 16'h0064);
			end
		end
		act(`CMD_CLEAR_PEAKS);
		rdx(`CMD_VIN_PEAK, 1'b0, 16'h0000);
		strobe(1'b0, 16'h0032, 1'b0);
		rdx(`CMD_IOUT_PEAK, 1'b1, 16'h0033);
		rdx(`CMD_INT_TEMP_PEAK, 1'b0, 16'h0032);
		for (int i = 0; i < LB; i++) begin
			@(posedge clk_sys);
			#1;
			log_wr_en = 1'b1;
			log_wr_idx = i[7:0];
			log_wr_data = 8'hA0 + i[7:0];
		end
		@(posedge clk_sys);
		#1;
		log_wr_en = 1'b0;
		act(`CMD_LOG_STORE);
		rdx(`CMD_LOG_READ, 1'b0, LB[15:0]);
		for (int i = 0; i < LB; i++) nxt(16'h00A0 + i[15:0], i == LB - 1);
		act(`CMD_LOG_ERASE);
		rdx(`CMD_LOG_READ, 1'b0, LB[15:0]);
		nxt({8'h00, `LOG_ERASED_BYTE}, 1'b0);
		pad_pins = 16'hBEEF;
		status_in = 8'h5A;
		repeat (3) @(posedge clk_sys);
		rdx(`CMD_PAD_STATE, 1'b0, 16'hBEEF);
		rdx(`CMD_FAMILY_STATUS, 1'b0, 16'h005A);
		rdx(`CMD_PART_CODE, 1'b0, {PC, 4'h9});
		host.xfer(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, q, e);
		chk("unknown code", 16'h0001, {15'h0000, e});
		test_done();
	end
	initial begin
		#2000000;
		n_fail++;
		test_done();
	end
endmodule
